// ### ppgc_pkg.sv
`default_nettype none
package ppgc_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PPGC_CNT_W = 16;
    localparam int PPGC_SEL_W = 4;
    localparam int PPGC_CR_W = 12;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] PPGC_OFS_CONF = 8'h00;
    localparam logic [7:0] PPGC_OFS_RUN_A = 8'h04;
    localparam logic [7:0] PPGC_OFS_RUN_B = 8'h08;
    localparam logic [7:0] PPGC_OFS_CR_A = 8'h0c;
    localparam logic [7:0] PPGC_OFS_CR_B = 8'h10;
    localparam logic [7:0] PPGC_OFS_MOD_A = 8'h14;
    localparam logic [7:0] PPGC_OFS_MOD_B = 8'h18;
    localparam logic [7:0] PPGC_OFS_PHASE = 8'h1c;
    localparam logic [7:0] PPGC_OFS_CNT_A = 8'h20;
    localparam logic [7:0] PPGC_OFS_CNT_B = 8'h24;

    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int PPGC_RUN_BIT = 0;
    localparam int PPGC_PHASE_BIT = 4;
    localparam int PPGC_CONF_RSV_LO = 6;
    localparam logic [PPGC_CR_W-1:0] PPGC_CR_MASK = 12'hff7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [2:0] PPGC_MODE_RST = 3'h0;
    localparam logic [1:0] PPGC_CONF_RSV_RST = 2'h0;
    localparam logic [PPGC_CR_W-1:0] PPGC_CR_RST = 12'h000;
    localparam logic [PPGC_SEL_W-1:0] PPGC_SEL_RST = 4'h0;

    // ****************************************************************
    // Pair mode codes
    // ****************************************************************
    typedef enum logic [2:0] {
        PPGC_MODE_PPG_A = 3'b010,
        PPGC_MODE_PPG_AB = 3'b011,
        PPGC_MODE_LOCK_CH0 = 3'b110,
        PPGC_MODE_LOCK_ALL = 3'b111
    } ppgc_mode_t;

    function automatic logic ppgc_is_lock(input logic [2:0] mode);
        ppgc_is_lock = (mode == PPGC_MODE_LOCK_CH0) || (mode == PPGC_MODE_LOCK_ALL);
    endfunction : ppgc_is_lock

endpackage : ppgc_pkg
`default_nettype wire

// ### ppgc_unit_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ppgc_unit_if;
    import ppgc_pkg::*;
    logic run;
    logic tick;
    logic [PPGC_CNT_W-1:0] count;
    modport ctrl (output run, output tick, input count);
    modport unit (input run, input tick, output count);
endinterface : ppgc_unit_if
`default_nettype wire

// ### ppgc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module ppgc_prescaler
    import ppgc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [PPGC_SEL_W-1:0] sel,
    output logic tick_q
);
    // A tick is issued once every 2**sel system clocks.
    logic [PPGC_CNT_W-1:0] div_q;
    logic [PPGC_CNT_W-1:0] mask;
    logic tick_d;

    assign mask = PPGC_CNT_W'((17'h1 << sel) - 17'h1);
    assign tick_d = (div_q & mask) == mask;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_q + 16'h1;
            tick_q <= tick_d;
        end
    end
endmodule : ppgc_prescaler
`default_nettype wire

// ### ppgc_counter.sv
`timescale 1ns/10ps
`default_nettype none
module ppgc_counter
    import ppgc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    ppgc_unit_if.unit u
);
    logic [PPGC_CNT_W-1:0] count_q;

    // A stopped unit holds zero; a running unit counts up on each tick.
    always_ff @(posedge mclk) begin
        if (!reset_n || !u.run) begin
            count_q <= '0;
        end else if (u.tick) begin
            count_q <= count_q + 16'h1;
        end
    end

    assign u.count = count_q;
endmodule : ppgc_counter
`default_nettype wire

// ### ppgc_top.sv
`timescale 1ns/10ps
`default_nettype none
module ppgc_top
    import ppgc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [1:0] chan_evt_a,
    input wire logic [1:0] chan_evt_b,
    output logic upd_a_q,
    output logic upd_b_q,
    output logic phase_swap_q,
    output logic [PPGC_CR_W-1:0] out_ctrl_a_q,
    output logic [PPGC_CR_W-1:0] out_ctrl_b_q,
    output logic [PPGC_CNT_W-1:0] count_a_q,
    output logic [PPGC_CNT_W-1:0] count_b_q
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic take;
    logic [31:0] rd_mux;

    assign take = hsel && htrans[1] && hready;
    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;

    // Reads take one wait state so a write just before is seen.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            hreadyout_q <= !(take && !hwrite);
            if (take) begin
                addr_q <= haddr[7:0];
            end
            if (rd_pend_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [2:0] mode_q;
    logic [1:0] conf_rsv_q;
    logic run_a_q;
    logic run_b_q;
    logic [PPGC_SEL_W-1:0] sel_a_q;
    logic [PPGC_SEL_W-1:0] sel_b_q;
    logic phase_sel_q;
    logic [PPGC_CR_W-1:0] cr_a_q;
    logic [PPGC_CR_W-1:0] cr_b_q;

    logic wr_conf;
    logic wr_run_a;
    logic wr_run_b;
    logic lock;
    logic run_b_eff;

    assign wr_conf = wr_pend_q && (addr_q == PPGC_OFS_CONF);
    assign wr_run_a = wr_pend_q && (addr_q == PPGC_OFS_RUN_A);
    assign wr_run_b = wr_pend_q && (addr_q == PPGC_OFS_RUN_B);
    assign lock = ppgc_is_lock(mode_q);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_q <= PPGC_MODE_RST;
            conf_rsv_q <= PPGC_CONF_RSV_RST;
            run_a_q <= 1'b0;
            run_b_q <= 1'b0;
            sel_a_q <= PPGC_SEL_RST;
            sel_b_q <= PPGC_SEL_RST;
            phase_sel_q <= 1'b0;
            cr_a_q <= PPGC_CR_RST;
            cr_b_q <= PPGC_CR_RST;
        end else begin
            if (wr_conf) begin
                mode_q <= hwdata[2:0];
                conf_rsv_q <= hwdata[PPGC_CONF_RSV_LO +: 2];
            end
            // Only bit 0 acts; bit 1 is expected to be written as zero.
            if (wr_run_a) begin
                run_a_q <= hwdata[PPGC_RUN_BIT];
            end
            if (wr_run_b) begin
                run_b_q <= hwdata[PPGC_RUN_BIT];
            end
            if (wr_pend_q && (addr_q == PPGC_OFS_MOD_A)) begin
                sel_a_q <= hwdata[PPGC_SEL_W-1:0];
            end
            if (wr_pend_q && (addr_q == PPGC_OFS_MOD_B)) begin
                sel_b_q <= hwdata[PPGC_SEL_W-1:0];
            end
            if (wr_pend_q && (addr_q == PPGC_OFS_PHASE)) begin
                phase_sel_q <= hwdata[PPGC_PHASE_BIT];
            end
            if (wr_pend_q && (addr_q == PPGC_OFS_CR_A)) begin
                cr_a_q <= hwdata[PPGC_CR_W-1:0] & PPGC_CR_MASK;
            end
            if (wr_pend_q && (addr_q == PPGC_OFS_CR_B)) begin
                cr_b_q <= hwdata[PPGC_CR_W-1:0] & PPGC_CR_MASK;
            end
        end
    end

    assign out_ctrl_a_q = cr_a_q;
    assign out_ctrl_b_q = cr_b_q;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    assign rd_mux =
        (addr_q == PPGC_OFS_CONF) ? {24'h0, conf_rsv_q, 3'h0, mode_q} :
        (addr_q == PPGC_OFS_RUN_A) ? {31'h0, run_a_q} :
        (addr_q == PPGC_OFS_RUN_B) ? {31'h0, run_b_eff} :
        (addr_q == PPGC_OFS_CR_A) ? {20'h0, cr_a_q} :
        (addr_q == PPGC_OFS_CR_B) ? {20'h0, cr_b_q} :
        (addr_q == PPGC_OFS_MOD_A) ? {28'h0, sel_a_q} :
        (addr_q == PPGC_OFS_MOD_B) ? {28'h0, sel_b_q} :
        (addr_q == PPGC_OFS_PHASE) ? {27'h0, phase_sel_q, 4'h0} :
        (addr_q == PPGC_OFS_CNT_A) ? {16'h0, count_a_q} :
        (addr_q == PPGC_OFS_CNT_B) ? {16'h0, count_b_q} :
        32'h0;

    // ****************************************************************
    // Count clocks and units
    // ****************************************************************
    logic tick_a;
    logic tick_b_own;
    logic tick_b;

    ppgc_prescaler u_pre_a (
        .mclk(mclk),
        .reset_n(reset_n),
        .sel(sel_a_q),
        .tick_q(tick_a)
    );

    ppgc_prescaler u_pre_b (
        .mclk(mclk),
        .reset_n(reset_n),
        .sel(sel_b_q),
        .tick_q(tick_b_own)
    );

    // Interlocked pairs run B from A's count clock.
    assign tick_b = lock ? tick_a : tick_b_own;

    // Unit B runs only in dual mode, or slaved to A when interlocked.
    assign run_b_eff = lock ? run_a_q :
        ((mode_q == PPGC_MODE_PPG_AB) && run_b_q);

    ppgc_unit_if ua_if ();
    ppgc_unit_if ub_if ();

    assign ua_if.run = run_a_q;
    assign ua_if.tick = tick_a;
    assign ub_if.run = run_b_eff;
    assign ub_if.tick = tick_b;
    assign count_a_q = ua_if.count;
    assign count_b_q = ub_if.count;

    ppgc_counter u_cnt_a (
        .mclk(mclk),
        .reset_n(reset_n),
        .u(ua_if.unit)
    );

    ppgc_counter u_cnt_b (
        .mclk(mclk),
        .reset_n(reset_n),
        .u(ub_if.unit)
    );

    // ****************************************************************
    // Compare-update timing and phase relation
    // ****************************************************************
    logic upd_a_d;

    assign upd_a_d = (mode_q == PPGC_MODE_LOCK_CH0) ? chan_evt_b[0] :
        (mode_q == PPGC_MODE_LOCK_ALL) ? |chan_evt_b :
        chan_evt_a[0];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            upd_a_q <= 1'b0;
            upd_b_q <= 1'b0;
            phase_swap_q <= 1'b0;
        end else begin
            upd_a_q <= upd_a_d;
            upd_b_q <= chan_evt_b[0];
            phase_swap_q <= phase_sel_q && (mode_q == PPGC_MODE_LOCK_ALL);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_stop_clears;
        (wr_run_a && !hwdata[PPGC_RUN_BIT]) |=> !run_a_q ##1 (count_a_q == 16'h0);
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear A");

    property p_start_counts;
        (wr_run_a && hwdata[PPGC_RUN_BIT]) |=> run_a_q;
    endproperty
    a_start_counts: assert property (p_start_counts) else $error("A did not start");

    property p_count_up;
        (run_a_q && $past(run_a_q) && $past(tick_a))
            |-> (count_a_q == $past(count_a_q) + 16'h1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("A missed a tick");

    // Under interlock both counters advance by the same step on every clock.
    property p_lock_clock;
        ($past(lock) && $past(run_a_q))
            |-> ((count_b_q - $past(count_b_q)) == (count_a_q - $past(count_a_q)));
    endproperty
    a_lock_clock: assert property (p_lock_clock) else $error("B clock not locked");

    // Outside interlock unit B counts on the ticks of its own divider.
    property p_free_clock;
        (!$past(lock) && $past(run_b_eff) && $past(tick_b_own))
            |-> (count_b_q == $past(count_b_q) + 16'h1);
    endproperty
    a_free_clock: assert property (p_free_clock) else $error("B clock not own");

    property p_lock_run;
        ($past(lock) && !$past(run_a_q)) |-> (count_b_q == 16'h0);
    endproperty
    a_lock_run: assert property (p_lock_run) else $error("B run not slaved");

    property p_lock_ignore_b;
        (lock && wr_run_b) |=> $stable(run_b_eff);
    endproperty
    a_lock_ignore_b: assert property (p_lock_ignore_b) else $error("B write acted");

    property p_single_idle;
        (mode_q == PPGC_MODE_PPG_A)[*2] |-> (count_b_q == 16'h0);
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("B ran in 010");

    property p_upd_ch0;
        ((mode_q == PPGC_MODE_LOCK_CH0) && chan_evt_b[0]) |=> upd_a_q;
    endproperty
    a_upd_ch0: assert property (p_upd_ch0) else $error("110 update missing");

    property p_upd_all;
        ((mode_q == PPGC_MODE_LOCK_ALL) && chan_evt_b[1]) |=> upd_a_q;
    endproperty
    a_upd_all: assert property (p_upd_all) else $error("111 update missing");

    property p_no_swap_110;
        (mode_q == PPGC_MODE_LOCK_CH0) |=> !phase_swap_q;
    endproperty
    a_no_swap_110: assert property (p_no_swap_110) else $error("swap under 110");

    property p_read_wait;
        (take && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read timing wrong");

endmodule : ppgc_top
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ppgc_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [1:0] chan_evt_a = 2'h0;
    logic [1:0] chan_evt_b = 2'h0;
    logic upd_a_q;
    logic upd_b_q;
    logic phase_swap_q;
    logic [PPGC_CR_W-1:0] out_ctrl_a_q;
    logic [PPGC_CR_W-1:0] out_ctrl_b_q;
    logic [PPGC_CNT_W-1:0] count_a_q;
    logic [PPGC_CNT_W-1:0] count_b_q;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] da;
    logic [15:0] db;

    ppgc_top dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .chan_evt_a(chan_evt_a), .chan_evt_b(chan_evt_b), .upd_a_q(upd_a_q),
        .upd_b_q(upd_b_q), .phase_swap_q(phase_swap_q), .out_ctrl_a_q(out_ctrl_a_q),
        .out_ctrl_b_q(out_ctrl_b_q), .count_a_q(count_a_q), .count_b_q(count_b_q));

    always #20 mclk = ~mclk;

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task close_out;
        $display("checks made %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            close_out();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Called just after a rising edge; returns at the edge that ends the data phase.
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask : rdchk

    // Counts advance over exactly 64 clocks; the dividers are periodic.
    task measure;
        logic [15:0] a0;
        logic [15:0] b0;
        @(posedge mclk);
        a0 = count_a_q;
        b0 = count_b_q;
        repeat (64) @(posedge mclk);
        da = count_a_q - a0;
        db = count_b_q - b0;
    endtask : measure

    // One-cycle channel event pulse, then the registered update strobe is checked.
    task pulse(input logic [1:0] ea, input logic [1:0] eb, input logic exp);
        chan_evt_a <= ea;
        chan_evt_b <= eb;
        @(posedge mclk);
        chan_evt_a <= 2'h0;
        chan_evt_b <= 2'h0;
        #1;
        chk({31'h0, upd_a_q}, {31'h0, exp});
        chk({31'h0, upd_b_q}, {31'h0, eb[0]});
        @(posedge mclk);
    endtask : pulse

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdchk(PPGC_OFS_CONF, 32'h0);
        rdchk(PPGC_OFS_RUN_A, 32'h0);
        rdchk(PPGC_OFS_CR_A, 32'h0);
        rdchk(PPGC_OFS_MOD_A, 32'h0);
        rdchk(PPGC_OFS_PHASE, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0);
        wr(PPGC_OFS_CONF, 32'hffff_ffff);
        rdchk(PPGC_OFS_CONF, 32'h0000_00c7);
        wr(PPGC_OFS_CR_B, 32'hffff_ffff);
        rdchk(PPGC_OFS_CR_B, 32'h0000_0ff7);
        chk({20'h0, out_ctrl_b_q}, 32'h0000_0ff7);
        wr(PPGC_OFS_CR_A, 32'h0000_0a5c);
        rdchk(PPGC_OFS_CR_A, 32'h0000_0a54);
        chk({20'h0, out_ctrl_a_q}, 32'h0000_0a54);
        wr(PPGC_OFS_CNT_A, 32'h0000_1234);
        rdchk(PPGC_OFS_CNT_A, 32'h0);
        end_test("registers");

        wr(PPGC_OFS_CONF, 32'h3);
        wr(PPGC_OFS_MOD_A, 32'h0);
        wr(PPGC_OFS_MOD_B, 32'h2);
        rdchk(PPGC_OFS_MOD_B, 32'h2);
        wr(PPGC_OFS_RUN_A, 32'h1);
        wr(PPGC_OFS_RUN_B, 32'h1);
        measure();
        chk({16'h0, da}, 32'd64);
        chk({16'h0, db}, 32'd16);
        pulse(2'h0, 2'h1, 1'b0);
        pulse(2'h1, 2'h0, 1'b1);
        wr(PPGC_OFS_RUN_A, 32'h0);
        repeat (3) @(posedge mclk);
        chk({16'h0, count_a_q}, 32'h0);
        chk({31'h0, count_b_q != 16'h0}, 32'h1);
        wr(PPGC_OFS_RUN_B, 32'h0);
        repeat (3) @(posedge mclk);
        chk({16'h0, count_b_q}, 32'h0);
        end_test("independent");

        wr(PPGC_OFS_CONF, 32'h2);
        wr(PPGC_OFS_RUN_B, 32'h1);
        rdchk(PPGC_OFS_RUN_B, 32'h0);
        repeat (20) @(posedge mclk);
        chk({16'h0, count_b_q}, 32'h0);
        wr(PPGC_OFS_RUN_B, 32'h0);
        end_test("single unit");

        wr(PPGC_OFS_CONF, 32'h6);
        wr(PPGC_OFS_MOD_A, 32'h1);
        wr(PPGC_OFS_MOD_B, 32'h0);
        wr(PPGC_OFS_PHASE, 32'h10);
        wr(PPGC_OFS_RUN_A, 32'h1);
        measure();
        chk({16'h0, da}, 32'd32);
        chk({16'h0, db}, 32'd32);
        chk({16'h0, count_b_q}, {16'h0, count_a_q});
        wr(PPGC_OFS_RUN_B, 32'h0);
        rdchk(PPGC_OFS_RUN_B, 32'h1);
        repeat (4) @(posedge mclk);
        chk({16'h0, count_b_q}, {16'h0, count_a_q});
        chk({31'h0, count_b_q != 16'h0}, 32'h1);
        chk({31'h0, phase_swap_q}, 32'h0);
        pulse(2'h1, 2'h0, 1'b0);
        pulse(2'h0, 2'h1, 1'b1);
        pulse(2'h0, 2'h2, 1'b0);
        wr(PPGC_OFS_RUN_A, 32'h0);
        repeat (3) @(posedge mclk);
        chk({16'h0, count_a_q}, 32'h0);
        chk({16'h0, count_b_q}, 32'h0);
        rdchk(PPGC_OFS_CNT_B, 32'h0);
        end_test("interlock channel zero");

        wr(PPGC_OFS_CONF, 32'h7);
        repeat (3) @(posedge mclk);
        chk({31'h0, phase_swap_q}, 32'h1);
        pulse(2'h0, 2'h2, 1'b1);
        pulse(2'h0, 2'h1, 1'b1);
        pulse(2'h1, 2'h0, 1'b0);
        end_test("interlock all channels");
        close_out();
    end
endmodule : tb
`default_nettype wire
